/* common/motor_cfg_pkg.sv */
// types of the motor driver configuration store
package motor_cfg_pkg;

   // word select code in the top two bits of a serial word
   typedef enum logic [1:0] {
      SEL_BRIDGE_ONE_TIMING,
      SEL_BRIDGE_TWO_TIMING,
      SEL_MODE_CURRENT,
      SEL_MONITOR_TEST
   } word_sel_t;

   typedef logic [15:0] cfg_word_t;

   // link-side state
   typedef struct packed {
      cfg_word_t frame;
   } link_state_t;

endpackage : motor_cfg_pkg

/* common/motor_cfg_regs.svh */
// offsets, field positions, reset values and timing counts of the motor driver configuration store
`ifndef MOTOR_CFG_REGS_SVH
`define MOTOR_CFG_REGS_SVH

// ----------------------------------------
// serial word framing
// ----------------------------------------
`define CFG_WORD_BITS        16
`define CFG_SEL_MSB          15
`define CFG_SEL_LSB          14
`define CFG_WORD_COUNT       4

// ----------------------------------------
// timing words (bridge one and bridge two)
// ----------------------------------------
`define TIM_BLANK_LSB        0
`define TIM_BLANK_MSB        1
`define TIM_OFF_LSB          2
`define TIM_OFF_MSB          6
`define TIM_FAST_LSB         7
`define TIM_FAST_MSB         10
`define TIM_SYNC_RECT_BIT    11

// ----------------------------------------
// mode and current word
// ----------------------------------------
`define MODE_B2_INT_BIT      0
`define MODE_B2_EXT_BIT      1
`define MODE_B2_PHASE_BIT    2
`define MODE_B2_RATIO_LSB    3
`define MODE_B2_RATIO_MSB    6
`define MODE_B1_INT_BIT      7
`define MODE_B1_EXT_BIT      8
`define MODE_B1_PHASE_BIT    9
`define MODE_B1_RATIO_LSB    10
`define MODE_B1_RATIO_MSB    13

// ----------------------------------------
// monitor and test word
// ----------------------------------------
`define MON_TEMP_OUT_BIT     0
`define MON_PUMP_OFF_BIT     1

// ----------------------------------------
// power-on values
// ----------------------------------------
`define RST_TIMING_WORD      16'h0040
`define RST_MODE_WORD        16'h0000
`define RST_MONITOR_WORD     16'h0000

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_PERIOD_NS        10
`define OSC_PERIOD_NS        250
`define OSC_CYCLES           (`OSC_PERIOD_NS / `CLK_PERIOD_NS)
`define BLANK_MULT_0         4
`define BLANK_MULT_1         6
`define BLANK_MULT_2         12
`define BLANK_MULT_3         24
`define OCP_QUALIFY_NS       1000
`define OCP_QUALIFY_CYCLES   (`OCP_QUALIFY_NS / `CLK_PERIOD_NS)
`define RESET_HOLD_MS        100
`define RESET_HOLD_CYCLES    (`RESET_HOLD_MS * 1000000 / `CLK_PERIOD_NS)
`define PUMP_MARGIN_V        5

`endif

/* logic/motor_driver_config_protection.sv */
// configuration store, serial write port and fault supervision of a dual full-bridge driver
`timescale 1ns/1ps
`default_nettype none
`include "motor_cfg_regs.svh"

module motor_driver_config_protection #(
   parameter int unsigned RESET_HOLD_CYCLES = `RESET_HOLD_CYCLES,
   parameter int unsigned OCP_QUALIFY       = `OCP_QUALIFY_CYCLES
) (
   // clock and reset
   input  wire logic                     clk_i,
   input  wire logic                     reset_n_i,
   // serial port (link clock domain), then standby and force-reset request pins
   input  wire logic                     serial_clk_i,
   input  wire logic                     serial_data_i,
   input  wire logic                     serial_latch_strobe_i,
   input  wire logic                     standby_request_n_i,
   input  wire logic                     force_reset_in_i,
   // analog comparator flags
   input  wire logic                     load_supply_uv_i,
   input  wire logic                     pump_voltage_low_i,
   input  wire logic                     thermal_fault_i,
   input  wire logic                     logic_supply_low_i,
   input  wire logic                     regulator_feedback_uv_i,
   // bridge chopping and current sense
   input  wire logic                     bridge_one_chop_in_i,
   input  wire logic                     bridge_two_chop_in_i,
   input  wire logic                     bridge_one_sense_i,
   input  wire logic                     bridge_two_sense_i,
   // bridge drive
   output logic                          bridge_one_source_on_o,
   output logic                          bridge_two_source_on_o,
   output logic                          drivers_enable_o,
   // regulators, pump, standby and overcurrent fault status
   output logic                          buck_enable_o,
   output logic                          charge_pump_enable_o,
   output logic                          standby_o,
   output logic                          overcurrent_fault_o,
   // open-drain pins and the temperature monitor enable
   output logic                          supply_good_out_o,
   output logic                          supply_good_out_oe_o,
   output logic                          host_reset_out_n_o,
   output logic                          host_reset_out_n_oe_o,
   output logic                          thermal_monitor_en_o,
   // stored configuration
   output motor_cfg_pkg::cfg_word_t      bridge_one_timing_word_o,
   output motor_cfg_pkg::cfg_word_t      bridge_two_timing_word_o,
   output motor_cfg_pkg::cfg_word_t      bridge_mode_current_word_o,
   output motor_cfg_pkg::cfg_word_t      monitor_test_word_o
);
   import motor_cfg_pkg::*;

   // ----------------------------------------
   // input synchroniser indices
   // ----------------------------------------
   localparam int NIN        = 12;
   localparam int I_STB      = 0;
   localparam int I_SLEEP_N  = 1;
   localparam int I_FORCE_RESET_IN     = 2;
   localparam int I_LOAD_UV  = 3;
   localparam int I_PUMP_LO  = 4;
   localparam int I_THERM    = 5;
   localparam int I_LOGIC_LO = 6;
   localparam int I_FB_UV    = 7;
   localparam int I_CHOP1    = 8;
   localparam int I_CHOP2    = 9;
   localparam int I_SENSE1   = 10;
   localparam int I_SENSE2   = 11;
   localparam int BW         = 10;
   localparam int QW         = $clog2(OCP_QUALIFY + 1);
   localparam int HW         = $clog2(RESET_HOLD_CYCLES + 1);

   typedef struct packed {
      logic [NIN-1:0]          meta;
      logic [NIN-1:0]          sync;
      logic                    stb_prev;
      logic [3:0][15:0]        words;
      logic                    ocp_latched;
      logic [1:0][BW-1:0]      blank_cnt;
      logic [1:0][QW-1:0]      qual_cnt;
      logic [1:0]              terminated;
      logic [1:0]              source_on;
      logic                    drivers_en;
      logic                    buck_en;
      logic                    supply_good;
      logic [HW-1:0]           hold_cnt;
      logic                    reset_released;
      logic                    standby;
   } core_state_t;

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [BW-1:0] blank_cycles(input logic [1:0] code);
      logic [BW-1:0] mult;
      mult = BW'(`BLANK_MULT_0);
      unique case (code)
         2'h0: mult = BW'(`BLANK_MULT_0);
         2'h1: mult = BW'(`BLANK_MULT_1);
         2'h2: mult = BW'(`BLANK_MULT_2);
         2'h3: mult = BW'(`BLANK_MULT_3);
      endcase
      return BW'(mult * BW'(`OSC_CYCLES));
   endfunction : blank_cycles

   function automatic cfg_word_t default_word(input logic [1:0] idx);
      cfg_word_t w;
      w = `RST_MONITOR_WORD;
      unique case (idx)
         2'h0, 2'h1: w = `RST_TIMING_WORD;
         2'h2:       w = `RST_MODE_WORD;
         2'h3:       w = `RST_MONITOR_WORD;
      endcase
      return w;
   endfunction : default_word

   // ----------------------------------------
   // link domain: serial shift register
   // ----------------------------------------
   // bits shift MSB first while the strobe is low; the strobe rising edge
   // freezes the frame, so the word is stable when the core samples it
   link_state_t link_ff;
   link_state_t nxt_link;

   always_comb
   begin
      nxt_link = link_ff;
      if (!serial_latch_strobe_i)
      begin
         nxt_link.frame = {link_ff.frame[14:0], serial_data_i};
      end
   end

   always_ff @(posedge serial_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         link_ff <= '0;
      end
      else
      begin
         link_ff <= nxt_link;
      end
   end

   // ----------------------------------------
   // core domain
   // ----------------------------------------
   core_state_t core_ff;
   core_state_t nxt_core;

   logic [NIN-1:0] raw_in;
   assign raw_in = {bridge_two_sense_i, bridge_one_sense_i,
                    bridge_two_chop_in_i, bridge_one_chop_in_i,
                    regulator_feedback_uv_i, logic_supply_low_i,
                    thermal_fault_i, pump_voltage_low_i, load_supply_uv_i,
                    force_reset_in_i, standby_request_n_i, serial_latch_strobe_i};

   always_comb
   begin
      logic       stb_rise;
      logic       thermal;
      logic       logic_low;
      logic       force_rst;
      logic       sleep;
      logic       ocp_event;
      logic       clear_words;
      logic       allowed;
      logic       hold_low;
      logic [1:0] chop;
      logic [1:0] sense;
      logic [1:0] blank_done;
      logic [1:0] blank_code;
      word_sel_t  sel;

      nxt_core   = core_ff;
      stb_rise   = 1'b0;
      thermal    = 1'b0;
      logic_low  = 1'b0;
      force_rst  = 1'b0;
      sleep      = 1'b0;
      ocp_event  = 1'b0;
      clear_words = 1'b0;
      allowed    = 1'b0;
      hold_low   = 1'b0;
      chop       = '0;
      sense      = '0;
      blank_done = '0;
      blank_code = '0;
      sel        = SEL_BRIDGE_ONE_TIMING;

      // two-stage synchronisers for every pin except the two clocks, the reset and the serial data
      nxt_core.meta     = raw_in;
      nxt_core.sync     = core_ff.meta;
      nxt_core.stb_prev = core_ff.sync[I_STB];

      stb_rise  = core_ff.sync[I_STB] && !core_ff.stb_prev;
      thermal   = core_ff.sync[I_THERM];
      logic_low = core_ff.sync[I_LOGIC_LO];
      force_rst = core_ff.sync[I_FORCE_RESET_IN];
      sleep     = !core_ff.sync[I_SLEEP_N];
      chop      = {core_ff.sync[I_CHOP2], core_ff.sync[I_CHOP1]};
      sense     = {core_ff.sync[I_SENSE2], core_ff.sync[I_SENSE1]};

      nxt_core.standby = sleep;

      // drivers run only with no thermal or overcurrent fault, no standby and no reset condition
      allowed = !thermal && !logic_low && !force_rst && !sleep
                && !core_ff.ocp_latched;
      nxt_core.drivers_en = allowed;

      // per-bridge source on-state, blanking and overcurrent qualification
      for (int b = 0; b < 2; b++)
      begin
         blank_code = (b == 0) ? core_ff.words[0][`TIM_BLANK_MSB:`TIM_BLANK_LSB]
                               : core_ff.words[1][`TIM_BLANK_MSB:`TIM_BLANK_LSB];
         blank_done[b] = core_ff.blank_cnt[b] >= blank_cycles(blank_code);

         if (!chop[b] || !allowed)
         begin
            nxt_core.terminated[b] = 1'b0;
            nxt_core.blank_cnt[b]  = '0;
         end
         else if (core_ff.source_on[b])
         begin
            if (!blank_done[b])
            begin
               nxt_core.blank_cnt[b] = core_ff.blank_cnt[b] + BW'(1);
            end
            else if (sense[b])
            begin
               // a shorted load is cut by current control once blanking ends
               nxt_core.terminated[b] = 1'b1;
            end
         end
         nxt_core.source_on[b] = chop[b] && allowed && !nxt_core.terminated[b];

         // qualification restarts whenever the source turns off, so a blank
         // time shorter than it never lets the fault trip
         if (core_ff.source_on[b] && sense[b])
         begin
            if (core_ff.qual_cnt[b] != QW'(OCP_QUALIFY))
            begin
               nxt_core.qual_cnt[b] = core_ff.qual_cnt[b] + QW'(1);
            end
            if (core_ff.qual_cnt[b] == QW'(OCP_QUALIFY - 1))
            begin
               ocp_event = 1'b1;
            end
         end
         else
         begin
            nxt_core.qual_cnt[b] = '0;
         end
      end

      // overcurrent latch: only a reset condition or standby clears it
      if (ocp_event)
      begin
         nxt_core.ocp_latched = 1'b1;
      end
      else if (sleep || force_rst || logic_low)
      begin
         nxt_core.ocp_latched = 1'b0;
      end

      // configuration words: reset conditions win over a pending write
      clear_words = logic_low || force_rst || sleep || ocp_event;
      if (clear_words)
      begin
         for (int w = 0; w < `CFG_WORD_COUNT; w++)
         begin
            nxt_core.words[w] = default_word(2'(w));
         end
      end
      else if (stb_rise)
      begin
         sel = word_sel_t'(link_ff.frame[`CFG_SEL_MSB:`CFG_SEL_LSB]);
         // stored without the select bits; bits 13:0 carry the fields
         nxt_core.words[sel] = {2'h0, link_ff.frame[`CFG_SEL_LSB-1:0]};
      end

      // buck switch and supply monitor
      nxt_core.buck_en     = !core_ff.sync[I_LOAD_UV] && !core_ff.sync[I_PUMP_LO]
                             && !thermal;
      nxt_core.supply_good = !core_ff.sync[I_LOAD_UV];

      // host reset: hold low, then count out the release delay
      hold_low = core_ff.sync[I_FB_UV] || force_rst;
      if (hold_low)
      begin
         nxt_core.hold_cnt       = '0;
         nxt_core.reset_released = 1'b0;
      end
      else if (!core_ff.reset_released)
      begin
         if (core_ff.hold_cnt == HW'(RESET_HOLD_CYCLES - 1))
         begin
            nxt_core.reset_released = 1'b1;
         end
         else
         begin
            nxt_core.hold_cnt = core_ff.hold_cnt + HW'(1);
         end
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         core_ff                   <= '0;
         core_ff.sync[I_SLEEP_N]   <= 1'b1;
         core_ff.meta[I_SLEEP_N]   <= 1'b1;
         // strobe idles high: a low start would fake a rising edge and write the cleared frame
         core_ff.meta[I_STB]       <= 1'b1;
         core_ff.sync[I_STB]       <= 1'b1;
         core_ff.stb_prev          <= 1'b1;
         core_ff.words[0]          <= `RST_TIMING_WORD;
         core_ff.words[1]          <= `RST_TIMING_WORD;
         core_ff.words[2]          <= `RST_MODE_WORD;
         core_ff.words[3]          <= `RST_MONITOR_WORD;
      end
      else
      begin
         core_ff <= nxt_core;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   // words leave only on the parallel outputs to the bridge and monitor logic; the serial port has no read path
   assign bridge_one_timing_word_o   = core_ff.words[0];
   assign bridge_two_timing_word_o   = core_ff.words[1];
   assign bridge_mode_current_word_o = core_ff.words[2];
   assign monitor_test_word_o        = core_ff.words[3];

   assign bridge_one_source_on_o = core_ff.source_on[0];
   assign bridge_two_source_on_o = core_ff.source_on[1];
   assign drivers_enable_o       = core_ff.drivers_en;
   assign buck_enable_o          = core_ff.buck_en;
   assign charge_pump_enable_o   = !core_ff.words[3][`MON_PUMP_OFF_BIT];
   assign standby_o              = core_ff.standby;
   assign overcurrent_fault_o    = core_ff.ocp_latched;

   // open-drain pins only ever drive low
   assign supply_good_out_o     = 1'b0;
   assign supply_good_out_oe_o  = !core_ff.supply_good;
   // in monitor mode the pin carries the analog temperature, so the digital
   // pull-down lets go entirely
   assign thermal_monitor_en_o  = core_ff.words[3][`MON_TEMP_OUT_BIT];
   assign host_reset_out_n_o    = 1'b0;
   assign host_reset_out_n_oe_o = !core_ff.reset_released && !thermal_monitor_en_o;

endmodule : motor_driver_config_protection
`default_nettype wire

/* tb/motor_driver_config_protection_bench.sv */
// self-checking bench for the motor driver configuration store
`timescale 1ns/1ps
`default_nettype none
module motor_driver_config_protection_bench;
   import motor_cfg_pkg::*;
   logic clk_i = 1'b0, reset_n_i = 1'b0, sclk, sdata, strobe;
   logic standby_n = 1'b1, force_rst = 1'b0, load_uv = 1'b0, pump_low = 1'b0, thermal = 1'b0;
   logic logic_low = 1'b0, fb_uv = 1'b0, chop = 1'b0, sense = 1'b0;
   logic src1, src2, drv_en, buck, pump_en, stby, fault, sg, sg_oe, rst, rst_oe, mon;
   cfg_word_t w0, w1, w2, w3;
   int fail_count = 0, tests_run = 0;

   always #5 clk_i = ~clk_i;

   motor_host_model u_motor_host_model (.serial_clk_o(sclk), .serial_data_o(sdata), .serial_latch_strobe_o(strobe));

   motor_driver_config_protection #(.RESET_HOLD_CYCLES(50), .OCP_QUALIFY(200)) u_motor_driver_config_protection (
      .clk_i(clk_i), .reset_n_i(reset_n_i), .serial_clk_i(sclk), .serial_data_i(sdata),
      .serial_latch_strobe_i(strobe), .standby_request_n_i(standby_n), .force_reset_in_i(force_rst),
      .load_supply_uv_i(load_uv), .pump_voltage_low_i(pump_low), .thermal_fault_i(thermal),
      .logic_supply_low_i(logic_low), .regulator_feedback_uv_i(fb_uv), .bridge_one_chop_in_i(chop),
      .bridge_two_chop_in_i(chop), .bridge_one_sense_i(sense), .bridge_two_sense_i(sense),
      .bridge_one_source_on_o(src1), .bridge_two_source_on_o(src2), .drivers_enable_o(drv_en),
      .buck_enable_o(buck), .charge_pump_enable_o(pump_en), .standby_o(stby), .overcurrent_fault_o(fault),
      .supply_good_out_o(sg), .supply_good_out_oe_o(sg_oe), .host_reset_out_n_o(rst),
      .host_reset_out_n_oe_o(rst_oe), .thermal_monitor_en_o(mon), .bridge_one_timing_word_o(w0),
      .bridge_two_timing_word_o(w1), .bridge_mode_current_word_o(w2), .monitor_test_word_o(w3));

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
   endtask : cyc

   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      tests_run++;
      if (got !== exp)
      begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic wr(input logic [1:0] sel, input logic [13:0] payload);
      u_motor_host_model.send_word({sel, payload});
      cyc(8);
   endtask : wr

   task automatic finish_test;
      if (fail_count == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : finish_test

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_words;
      logic [13:0] pat [4] = '{14'h0FFF, 14'h0AAA, 14'h1555, 14'h0003};
      check("w0 default", 16'h0040, w0);
      check("w1 default", 16'h0040, w1);
      check("w2 default", 16'h0000, w2);
      check("w3 default", 16'h0000, w3);
      for (int i = 0; i < 4; i++)
         wr(i[1:0], pat[i]);
      check("w0", {2'b00, pat[0]}, w0);
      check("w1", {2'b00, pat[1]}, w1);
      check("w2", {2'b00, pat[2]}, w2);
      check("w3", {2'b00, pat[3]}, w3);
      @(posedge clk_i) fb_uv <= 1'b1;
      cyc(8);
      check("pump en", 16'h0000, pump_en);
      check("monitor en", 16'h0001, mon);
      check("reset oe", 16'h0000, rst_oe);
      wr(2'b11, 14'h0000);
      check("pump en", 16'h0001, pump_en);
      check("reset oe", 16'h0001, rst_oe);
   endtask : t_words

   task automatic t_reset_out;
      @(posedge clk_i) fb_uv <= 1'b0;
      cyc(20);
      fb_uv <= 1'b1;
      cyc(2);
      fb_uv <= 1'b0;
      cyc(40);
      check("reset oe held", 16'h0001, rst_oe);
      cyc(20);
      check("reset oe released", 16'h0000, rst_oe);
      force_rst <= 1'b1;
      cyc(8);
      check("reset oe forced", 16'h0001, rst_oe);
      check("w0 forced", 16'h0040, w0);
      force_rst <= 1'b0;
      cyc(70);
      check("reset oe after force", 16'h0000, rst_oe);
   endtask : t_reset_out

   task automatic t_thermal;
      wr(2'b01, 14'h0ABC);
      @(posedge clk_i) thermal <= 1'b1;
      cyc(30);
      check("drv thermal", 16'h0000, drv_en);
      check("buck thermal", 16'h0000, buck);
      check("w1 kept", 16'h0ABC, w1);
      thermal <= 1'b0;
      pump_low <= 1'b1;
      cyc(8);
      check("drv resumed", 16'h0001, drv_en);
      check("buck pump low", 16'h0000, buck);
      pump_low <= 1'b0;
      load_uv <= 1'b1;
      cyc(8);
      check("buck uv", 16'h0000, buck);
      check("supply good oe", 16'h0001, sg_oe);
      load_uv <= 1'b0;
      cyc(8);
      check("buck on", 16'h0001, buck);
      check("supply good oe", 16'h0000, sg_oe);
      check("supply good drive", 16'h0000, sg);
      check("reset drive", 16'h0000, rst);
   endtask : t_thermal

   task automatic overcurrent_qualify_time;
      int on_n = 0, off_n = 0;
      @(posedge clk_i) chop <= 1'b1;
      sense <= 1'b1;
      repeat (400)
      begin
         @(posedge clk_i);
         if (src1 === 1'b1) on_n++;
         else off_n++;
      end
      check("no fault short blank", 16'h0000, fault);
      check("source cut seen", 16'h0001, 16'(on_n > 0 && on_n < 400));
      check("src2 cut", 16'h0000, src2);
      chop <= 1'b0;
      sense <= 1'b0;
      cyc(4);
      wr(2'b00, 14'h0043);
      wr(2'b10, 14'h1234);
      @(posedge clk_i) chop <= 1'b1;
      sense <= 1'b1;
      cyc(400);
      check("fault", 16'h0001, fault);
      check("w0 cleared", 16'h0040, w0);
      check("w2 cleared", 16'h0000, w2);
      check("src1 off on fault", 16'h0000, src1);
      chop <= 1'b0;
      sense <= 1'b0;
      cyc(20);
      check("fault latched", 16'h0001, fault);
      standby_n <= 1'b0;
      cyc(8);
      check("fault cleared", 16'h0000, fault);
      check("standby", 16'h0001, stby);
      check("drv standby", 16'h0000, drv_en);
      standby_n <= 1'b1;
      cyc(8);
      check("standby left", 16'h0000, stby);
   endtask : overcurrent_qualify_time

   task automatic t_logic_low;
      wr(2'b10, 14'h0155);
      @(posedge clk_i) logic_low <= 1'b1;
      cyc(8);
      check("w2 logic low", 16'h0000, w2);
      check("drv logic low", 16'h0000, drv_en);
      logic_low <= 1'b0;
      cyc(8);
      wr(2'b10, 14'h0155);
      check("w2 rewritten", 16'h0155, w2);
   endtask : t_logic_low

   // ----------------------------------------
   // main sequence and watchdog
   // ----------------------------------------
   initial
   begin
      cyc(6);
      reset_n_i <= 1'b1;
      cyc(80);
      t_words();
      t_reset_out();
      t_thermal();
      overcurrent_qualify_time();
      t_logic_low();
      finish_test();
   end

   initial
   begin
      #300000;
      fail_count++;
      finish_test();
   end
endmodule : motor_driver_config_protection_bench
`default_nettype wire

/* tb/motor_driver_config_protection_sva.sv */
// checker for the motor driver configuration store
`timescale 1ns/1ps
`default_nettype none
`include "motor_cfg_regs.svh"
module motor_cfg_sva #(
   parameter int unsigned RESET_HOLD_CYCLES = 50
) (
   input wire logic                     clk_i,
   input wire logic                     reset_n_i,
   input wire logic                     regulator_feedback_uv_i,
   input wire logic                     force_reset_in_i,
   input wire logic                     load_supply_uv_i,
   input wire logic                     pump_voltage_low_i,
   input wire logic                     thermal_fault_i,
   input wire logic                     standby_request_n_i,
   input wire logic                     logic_supply_low_i,
   input wire logic                     buck_enable_o,
   input wire logic                     drivers_enable_o,
   input wire logic                     supply_good_out_oe_o,
   input wire logic                     host_reset_out_n_oe_o,
   input wire logic                     thermal_monitor_en_o,
   input wire logic                     charge_pump_enable_o,
   input wire logic                     standby_o,
   input wire logic                     overcurrent_fault_o,
   input wire motor_cfg_pkg::cfg_word_t bridge_one_timing_word_o,
   input wire motor_cfg_pkg::cfg_word_t monitor_test_word_o
);
   import motor_cfg_pkg::*;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);

   // cycles since both reset-holding conditions went away, saturating
   int unsigned clear_cnt_ff;
   always_ff @(posedge clk_i or negedge reset_n_i)
      if (!reset_n_i)
         clear_cnt_ff <= 0;
      else if (regulator_feedback_uv_i || force_reset_in_i)
         clear_cnt_ff <= 0;
      else if (clear_cnt_ff < RESET_HOLD_CYCLES)
         clear_cnt_ff <= clear_cnt_ff + 1;

   a_buck_fault_off: assert property ((load_supply_uv_i || pump_voltage_low_i || thermal_fault_i)[*5]
      |=> !buck_enable_o) else $error("buck on during fault");
   a_thermal_drv_off: assert property (thermal_fault_i[*5] |=> !drivers_enable_o && !buck_enable_o)
      else $error("outputs on during thermal fault");
   a_supply_good_low: assert property (load_supply_uv_i[*5] |=> supply_good_out_oe_o)
      else $error("supply good not pulled low");
   a_supply_good_rel: assert property (!load_supply_uv_i[*5] |=> !supply_good_out_oe_o)
      else $error("supply good not released");
   a_logic_low_clr: assert property (logic_supply_low_i[*5]
      |=> !drivers_enable_o && bridge_one_timing_word_o == `RST_TIMING_WORD) else $error("logic low kept state");
   a_ocp_clears: assert property ($rose(overcurrent_fault_o) |-> ##[0:1]
      (bridge_one_timing_word_o == `RST_TIMING_WORD && monitor_test_word_o == `RST_MONITOR_WORD))
      else $error("fault did not clear words");
   a_ocp_latched: assert property ((standby_request_n_i && !force_reset_in_i && !logic_supply_low_i)[*5]
      ##0 overcurrent_fault_o |=> overcurrent_fault_o) else $error("fault latch dropped");
   a_force_reset: assert property (force_reset_in_i[*5]
      |=> host_reset_out_n_oe_o && bridge_one_timing_word_o == `RST_TIMING_WORD) else $error("force reset ignored");
   a_reset_hold: assert property ($fell(host_reset_out_n_oe_o) && !thermal_monitor_en_o
      |-> clear_cnt_ff >= RESET_HOLD_CYCLES) else $error("reset released early");
   a_monitor_pin: assert property (thermal_monitor_en_o
      |-> !host_reset_out_n_oe_o && monitor_test_word_o[`MON_TEMP_OUT_BIT]) else $error("monitor pin driven");
   a_pump_off: assert property (charge_pump_enable_o != monitor_test_word_o[`MON_PUMP_OFF_BIT])
      else $error("pump enable wrong");
   a_standby_state: assert property (!standby_request_n_i[*5] |=> standby_o && !drivers_enable_o)
      else $error("standby not entered");
endmodule : motor_cfg_sva

bind motor_driver_config_protection motor_cfg_sva #(.RESET_HOLD_CYCLES(RESET_HOLD_CYCLES)) u_motor_cfg_sva (
   .clk_i(clk_i), .reset_n_i(reset_n_i), .regulator_feedback_uv_i(regulator_feedback_uv_i),
   .force_reset_in_i(force_reset_in_i), .load_supply_uv_i(load_supply_uv_i),
   .pump_voltage_low_i(pump_voltage_low_i), .thermal_fault_i(thermal_fault_i),
   .standby_request_n_i(standby_request_n_i), .logic_supply_low_i(logic_supply_low_i),
   .buck_enable_o(buck_enable_o), .drivers_enable_o(drivers_enable_o),
   .supply_good_out_oe_o(supply_good_out_oe_o), .host_reset_out_n_oe_o(host_reset_out_n_oe_o),
   .thermal_monitor_en_o(thermal_monitor_en_o), .charge_pump_enable_o(charge_pump_enable_o),
   .standby_o(standby_o), .overcurrent_fault_o(overcurrent_fault_o),
   .bridge_one_timing_word_o(bridge_one_timing_word_o), .monitor_test_word_o(monitor_test_word_o));
`default_nettype wire

/* tb/motor_host_model.sv */
// host side model that writes configuration words over the serial port
`timescale 1ns/1ps
`default_nettype none
module motor_host_model (
   // serial port
   output logic serial_clk_o,
   output logic serial_data_o,
   output logic serial_latch_strobe_o
);
   initial
   begin
      serial_clk_o          = 1'b0;
      serial_data_o         = 1'b1;
      serial_latch_strobe_o = 1'b1;
   end

   // msb first, link clock still outside frames
   task automatic send_word(input logic [15:0] w);
      #7 serial_latch_strobe_o = 1'b0;
      for (int i = 15; i >= 0; i--)
      begin
         serial_data_o = w[i];
         #15 serial_clk_o = 1'b1;
         #15 serial_clk_o = 1'b0;
      end
      // released data line shows the inverse so a stale bit never looks valid
      serial_data_o = ~w[0];
      #15 serial_latch_strobe_o = 1'b1;
      #60;
   endtask : send_word
endmodule : motor_host_model
`default_nettype wire
